// >>> design/sfq_pkg.sv
package sfq_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_CLK_CFG = 8'h14;
  localparam logic [7:0] OFF_DMA     = 8'h1c;
  localparam logic [7:0] OFF_INT_FL  = 8'h20;
  localparam logic [7:0] OFF_INT_EN  = 8'h24;
  localparam logic [7:0] OFF_WAKE_FL = 8'h28;
  localparam logic [7:0] OFF_WAKE_EN = 8'h2c;
  localparam logic [7:0] OFF_STAT    = 8'h30;
  localparam logic [7:0] OFF_CTRL    = 8'h34;
  localparam logic [7:0] OFF_DATA    = 8'h38;

  // Queue control field positions.
  localparam int RX_DMA_EN_BIT = 31;
  localparam int RX_CNT_LSB    = 24;
  localparam int RX_CLR_BIT    = 23;
  localparam int RX_EN_BIT     = 22;
  localparam int RX_LVL_LSB    = 16;
  localparam int TX_DMA_EN_BIT = 15;
  localparam int TX_CNT_LSB    = 8;
  localparam int TX_CLR_BIT    = 7;
  localparam int TX_EN_BIT     = 6;
  localparam int TX_LVL_LSB    = 0;

  // Interrupt flag positions.
  localparam int FL_RX_UND   = 15;
  localparam int FL_RX_OVR   = 14;
  localparam int FL_TX_UND   = 13;
  localparam int FL_TX_OVR   = 12;
  localparam int FL_M_DONE   = 11;
  localparam int FL_ABORT    = 9;
  localparam int FL_FAULT    = 8;
  localparam int FL_SS_DEAS  = 5;
  localparam int FL_SS_ASRT  = 4;
  localparam int FL_RX_FULL  = 3;
  localparam int FL_RX_LEVEL = 2;
  localparam int FL_TX_EMPTY = 1;
  localparam int FL_TX_LEVEL = 0;

  // Flags that count as errors and survive DMA masking, implemented flags, and flag reset value.
  localparam logic [15:0] ERR_MASK = 16'hf300;
  localparam logic [15:0] FL_IMPL  = 16'hfb3f;
  localparam logic [15:0] FL_RESET = 16'h0002;

  // Reset values, and the refused receive threshold.
  localparam logic [4:0] TX_LVL_RESET = 5'h10;
  localparam logic [4:0] RX_LVL_BAD   = 5'h1f;
  localparam logic [7:0] TROUGH_RESET = 8'h00;

  // Own control register bit positions.
  localparam int CTRL_ROLE_BIT = 1;
  localparam int CTRL_MM_BIT   = 2;

  // Events from the shifter side, one-cycle pulses.
  typedef struct packed {
    logic rx_push;
    logic tx_pop;
    logic char_abort;
    logic collision;
    logic xfer_start;
    logic xfer_done;
  } sfq_evt_s;

endpackage

// >>> design/sfq_core.sv
// Functional notes
// - Eight-bit trough count sets SCK low time; zero disables, only with zero prescale.
// - Receive DMA enable gives receive requests, masks non-error interrupts; clear cancels.
// - Transmit DMA enable gives transmit requests, masks non-error interrupts; clear cancels.
// - Read-only counts show entries held in receive and transmit queues.
// - Writing one to receive clear empties receive queue and its flags except overrun.
// - Each queue has its own enable bit.
// - Receive count above threshold raises request and sets receive-level flag.
// - Writing one to transmit clear empties queue, flags and pending request.
// - Transmit count below threshold, reset 0x10, raises request and sets flag.
// - Reading empty receive queue sets sticky underrun flag, write one clears.
// - Slave push into full receive queue sets overrun; master stalls SCK instead.
// - Slave shift from empty transmit queue sets underrun; master stalls SCK instead.
// - Writing the full transmit queue sets transmit overrun.
// - Master sets done flag when all transactions complete.
// - Slave sets abort flag when select drops mid-character.
// - Multi-master with select input asserted or collision sets fault flag.
// - Select deassert and assert edges set separate write-one-clear flags.
// - Receive full and transmit empty flags; transmit empty resets to one.
// - Each interrupt flag has an enable at the same bit position.
// - Four wake flags, each gated by its own enable, write one clears.
// - Busy follows transfer in master mode, active select in slave mode.
// - Role select one means master, zero means slave.
module sfq_core #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire sfq_pkg::sfq_evt_s evt,
  input wire logic [WIDTH-1:0] rx_char,
  output logic [WIDTH-1:0] tx_char,
  input wire logic target_select_line,
  input wire logic sel_in_asserted,
  output logic controller_role_select,
  output logic [7:0] sck_trough_count,
  output logic sck_stall,
  output logic rx_dma_req,
  output logic tx_dma_req,
  output logic irq,
  output logic wake
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam int AW = $clog2(DEPTH);

  // Sizes beyond the six-bit count fields are refused when the design is built.
  if (DEPTH < 2 || DEPTH > 63 || WIDTH < 1 || WIDTH > 32) begin : g_bad_size
    $error("sfq_core: unsupported DEPTH or WIDTH");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [7:0] trough_r;
  logic rx_dma_en_r, tx_dma_en_r, rx_en_r, tx_en_r;
  logic [4:0] rx_lvl_r, tx_lvl_r;
  logic [15:0] fl_r, ie_r;
  logic [3:0] wfl_r, wen_r;
  logic role_r, mm_r, busy_r, sel_d_r;
  logic [WIDTH-1:0] rxq [DEPTH];
  logic [WIDTH-1:0] txq [DEPTH];
  logic [AW-1:0] rx_wp_r, rx_rp_r, tx_wp_r, tx_rp_r;
  logic [CW-1:0] rx_cnt_r, tx_cnt_r;

  wire wr_cfg = reg_wr && reg_addr == sfq_pkg::OFF_CLK_CFG;
  wire wr_dma = reg_wr && reg_addr == sfq_pkg::OFF_DMA;
  wire wr_fl = reg_wr && reg_addr == sfq_pkg::OFF_INT_FL;
  wire wr_wfl = reg_wr && reg_addr == sfq_pkg::OFF_WAKE_FL;
  wire wr_data = reg_wr && reg_addr == sfq_pkg::OFF_DATA;
  wire rd_data = reg_rd && reg_addr == sfq_pkg::OFF_DATA;
  wire rx_clr = wr_dma && reg_wdata[sfq_pkg::RX_CLR_BIT];
  wire tx_clr = wr_dma && reg_wdata[sfq_pkg::TX_CLR_BIT];

  wire rx_full = rx_cnt_r == CW'(DEPTH);
  wire rx_empty = rx_cnt_r == '0;
  wire tx_full = tx_cnt_r == CW'(DEPTH);
  wire tx_empty = tx_cnt_r == '0;
  // Queue moves; a register-side push or pop blocked by full or empty, or a shifter-side one in slave role, becomes an error event.
  wire rx_push = evt.rx_push && rx_en_r && !rx_full;
  wire rx_pop = rd_data && rx_en_r && !rx_empty;
  wire tx_push = wr_data && tx_en_r && !tx_full;
  wire tx_pop = evt.tx_pop && tx_en_r && !tx_empty;
  wire rx_lvl_hit = rx_cnt_r > CW'(rx_lvl_r);
  wire tx_lvl_hit = tx_cnt_r < CW'(tx_lvl_r);

  ////////////////////////////////////////////////////////////////////////////
  // Clock configuration: trough count only lives here.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trough_r <= sfq_pkg::TROUGH_RESET;
    end else if (wr_cfg) begin
      trough_r <= reg_wdata[7:0];
    end
  end
  // Zero means low-time control off; the clock generator owns prescale legality.
  assign sck_trough_count = trough_r;

  // Queue control bits.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_dma_en_r <= 1'b0;
      tx_dma_en_r <= 1'b0;
      rx_en_r <= 1'b0;
      tx_en_r <= 1'b0;
      rx_lvl_r <= '0;
      tx_lvl_r <= sfq_pkg::TX_LVL_RESET;
    end else if (wr_dma) begin
      rx_dma_en_r <= reg_wdata[sfq_pkg::RX_DMA_EN_BIT];
      tx_dma_en_r <= reg_wdata[sfq_pkg::TX_DMA_EN_BIT];
      rx_en_r <= reg_wdata[sfq_pkg::RX_EN_BIT];
      tx_en_r <= reg_wdata[sfq_pkg::TX_EN_BIT];
      // The invalid threshold is refused so the level compare stays meaningful.
      if (reg_wdata[sfq_pkg::RX_LVL_LSB +: 5] != sfq_pkg::RX_LVL_BAD) begin
        rx_lvl_r <= reg_wdata[sfq_pkg::RX_LVL_LSB +: 5];
      end
      tx_lvl_r <= reg_wdata[sfq_pkg::TX_LVL_LSB +: 5];
    end
  end

  // Enables and own control register.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ie_r <= '0;
      wen_r <= '0;
      role_r <= 1'b0;
      mm_r <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == sfq_pkg::OFF_INT_EN) begin
        ie_r <= reg_wdata[15:0] & sfq_pkg::FL_IMPL;
      end
      if (reg_addr == sfq_pkg::OFF_WAKE_EN) begin
        wen_r <= reg_wdata[3:0];
      end
      if (reg_addr == sfq_pkg::OFF_CTRL) begin
        role_r <= reg_wdata[sfq_pkg::CTRL_ROLE_BIT];
        mm_r <= reg_wdata[sfq_pkg::CTRL_MM_BIT];
      end
    end
  end
  assign controller_role_select = role_r;

  ////////////////////////////////////////////////////////////////////////////
  // Storage for both queues, then receive queue counters.
  always_ff @(posedge clock) begin
    if (rx_push) begin
      rxq[rx_wp_r] <= rx_char;
    end
    if (tx_push) begin
      txq[tx_wp_r] <= reg_wdata[WIDTH-1:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_wp_r <= '0;
      rx_rp_r <= '0;
      rx_cnt_r <= '0;
    end else if (rx_clr) begin
      rx_wp_r <= '0;
      rx_rp_r <= '0;
      rx_cnt_r <= '0;
    end else begin
      if (rx_push) begin
        rx_wp_r <= (rx_wp_r == AW'(DEPTH - 1)) ? '0 : rx_wp_r + 1'b1;
      end
      if (rx_pop) begin
        rx_rp_r <= (rx_rp_r == AW'(DEPTH - 1)) ? '0 : rx_rp_r + 1'b1;
      end
      rx_cnt_r <= rx_cnt_r + CW'(rx_push) - CW'(rx_pop);
    end
  end

  // Transmit queue pointers; the clear wins over any push in the same cycle.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_wp_r <= '0;
      tx_rp_r <= '0;
      tx_cnt_r <= '0;
    end else if (tx_clr) begin
      tx_wp_r <= '0;
      tx_rp_r <= '0;
      tx_cnt_r <= '0;
    end else begin
      if (tx_push) begin
        tx_wp_r <= (tx_wp_r == AW'(DEPTH - 1)) ? '0 : tx_wp_r + 1'b1;
      end
      if (tx_pop) begin
        tx_rp_r <= (tx_rp_r == AW'(DEPTH - 1)) ? '0 : tx_rp_r + 1'b1;
      end
      tx_cnt_r <= tx_cnt_r + CW'(tx_push) - CW'(tx_pop);
    end
  end

  // Transmit head is registered so the shifter sees stable data.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_char <= '0;
    end else begin
      tx_char <= txq[tx_rp_r];
    end
  end

  // A master never sets receive overrun or transmit underrun: it holds SCK until software catches up.
  assign sck_stall = role_r && (rx_full || tx_empty);

  ////////////////////////////////////////////////////////////////////////////
  // Flag set terms.
  logic [15:0] fl_set;
  always_comb begin
    fl_set = '0;
    fl_set[sfq_pkg::FL_RX_UND] = rd_data && rx_empty;
    fl_set[sfq_pkg::FL_RX_OVR] = !role_r && evt.rx_push && rx_full;
    fl_set[sfq_pkg::FL_TX_UND] = !role_r && evt.tx_pop && tx_empty;
    fl_set[sfq_pkg::FL_TX_OVR] = wr_data && tx_full;
    fl_set[sfq_pkg::FL_M_DONE] = role_r && evt.xfer_done;
    fl_set[sfq_pkg::FL_ABORT] = !role_r && evt.char_abort;
    fl_set[sfq_pkg::FL_FAULT] = role_r && mm_r && (sel_in_asserted || evt.collision);
    fl_set[sfq_pkg::FL_SS_DEAS] = sel_d_r && !target_select_line;
    fl_set[sfq_pkg::FL_SS_ASRT] = !sel_d_r && target_select_line;
    // A receive clear must leave its level flags down, so their set terms yield to it.
    fl_set[sfq_pkg::FL_RX_FULL] = rx_full && !rx_clr;
    fl_set[sfq_pkg::FL_RX_LEVEL] = rx_lvl_hit && !rx_clr;
    fl_set[sfq_pkg::FL_TX_EMPTY] = tx_empty;
    fl_set[sfq_pkg::FL_TX_LEVEL] = tx_lvl_hit;
  end

  // Queue clears drop that queue's pending flags, receive overrun excepted; fresh events still win.
  logic [15:0] fl_clr;
  always_comb begin
    fl_clr = wr_fl ? reg_wdata[15:0] : '0;
    if (rx_clr) begin
      fl_clr = fl_clr | 16'h800c;
    end
    if (tx_clr) begin
      fl_clr = fl_clr | 16'h3003;
    end
  end

  // Sticky interrupt flags, set wins over clear.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fl_r <= sfq_pkg::FL_RESET;
    end else begin
      fl_r <= ((fl_r & ~fl_clr) | fl_set) & sfq_pkg::FL_IMPL;
    end
  end

  // Wake flags record their conditions only when enabled.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wfl_r <= '0;
    end else begin
      wfl_r <= (wfl_r & ~(wr_wfl ? reg_wdata[3:0] : 4'h0))
             | (wen_r & {rx_full, rx_lvl_hit, tx_empty, tx_lvl_hit});
    end
  end
  assign wake = |wfl_r;

  // Select edge tracking and busy status.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_d_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      sel_d_r <= target_select_line;
      if (role_r) begin
        if (evt.xfer_start) begin
          busy_r <= 1'b1;
        end else if (evt.xfer_done) begin
          busy_r <= 1'b0;
        end
      end else begin
        busy_r <= target_select_line;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DMA requests drop as soon as their enable clears.
  assign rx_dma_req = rx_dma_en_r && rx_lvl_hit;
  assign tx_dma_req = tx_dma_en_r && tx_lvl_hit && !tx_clr;

  // Either DMA enable hides the data flags, leaving only errors.
  wire [15:0] irq_mask = (rx_dma_en_r || tx_dma_en_r) ? sfq_pkg::ERR_MASK : 16'hffff;
  assign irq = |(fl_r & ie_r & irq_mask);

  // Read mux, answer one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        sfq_pkg::OFF_CLK_CFG: reg_rdata <= {24'h0, trough_r};
        sfq_pkg::OFF_DMA: reg_rdata <= {rx_dma_en_r, 1'b0, 6'(rx_cnt_r), 1'b0, rx_en_r,
                                        1'b0, rx_lvl_r, tx_dma_en_r, 1'b0, 6'(tx_cnt_r),
                                        1'b0, tx_en_r, 1'b0, tx_lvl_r};
        sfq_pkg::OFF_INT_FL: reg_rdata <= {16'h0, fl_r};
        sfq_pkg::OFF_INT_EN: reg_rdata <= {16'h0, ie_r};
        sfq_pkg::OFF_WAKE_FL: reg_rdata <= {28'h0, wfl_r};
        sfq_pkg::OFF_WAKE_EN: reg_rdata <= {28'h0, wen_r};
        sfq_pkg::OFF_STAT: reg_rdata <= {31'h0, busy_r};
        sfq_pkg::OFF_CTRL: reg_rdata <= {29'h0, mm_r, role_r, 1'b0};
        sfq_pkg::OFF_DATA: reg_rdata <= 32'(rxq[rx_rp_r]);
        default: reg_rdata <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_tx_ovr_write;
    wr_data && tx_full;
  endsequence

  a_tx_ovr_flag: assert property (@(posedge clock) disable iff (!rst_n)
    s_tx_ovr_write |=> fl_r[sfq_pkg::FL_TX_OVR]) else $error("tx overrun not flagged");
  a_rx_und_flag: assert property (@(posedge clock) disable iff (!rst_n)
    rd_data && rx_empty |=> fl_r[sfq_pkg::FL_RX_UND]) else $error("rx underrun lost");
  a_master_no_ovr: assert property (@(posedge clock) disable iff (!rst_n)
    role_r && !fl_r[sfq_pkg::FL_RX_OVR] && !wr_fl |=> !fl_r[sfq_pkg::FL_RX_OVR])
    else $error("master set rx overrun");
  a_rx_dma_cancel: assert property (@(posedge clock) disable iff (!rst_n)
    !rx_dma_en_r |-> !rx_dma_req) else $error("rx dma req without enable");
  a_tx_clr_empty: assert property (@(posedge clock) disable iff (!rst_n)
    tx_clr |=> (tx_cnt_r == '0) ##1 fl_r[sfq_pkg::FL_TX_EMPTY])
    else $error("tx clear failed");
  a_rx_clr_empty: assert property (@(posedge clock) disable iff (!rst_n)
    rx_clr |=> rx_cnt_r == '0 && !fl_r[sfq_pkg::FL_RX_FULL] && !fl_r[sfq_pkg::FL_RX_LEVEL])
    else $error("rx clear failed");
  a_irq_dma_mask: assert property (@(posedge clock) disable iff (!rst_n)
    (rx_dma_en_r || tx_dma_en_r) && ((fl_r & ie_r & sfq_pkg::ERR_MASK) == '0) |-> !irq)
    else $error("data irq while dma enabled");
  a_busy_slave: assert property (@(posedge clock) disable iff (!rst_n)
    !role_r && $past(!role_r) |-> busy_r == $past(target_select_line))
    else $error("slave busy wrong");
  a_ss_edge_flag: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(target_select_line) |=> fl_r[sfq_pkg::FL_SS_ASRT]) else $error("select edge lost");
  a_cnt_bound: assert property (@(posedge clock) disable iff (!rst_n)
    rx_cnt_r <= CW'(DEPTH) && tx_cnt_r <= CW'(DEPTH)) else $error("count overflow");

endmodule

// >>> verification/sfq_far_end.sv
// Behavioural far side: shifter events, select lines and received characters.
module sfq_far_end (
  input wire logic clock,
  output sfq_pkg::sfq_evt_s evt,
  output logic [15:0] rx_char,
  output logic target_select_line,
  output logic sel_in_asserted
);
  timeunit 1ns;
  timeprecision 1ns;

  // Lines idle with no event and no select at time zero.
  initial begin
    evt = '0;
    rx_char = '0;
    target_select_line = 1'b0;
    sel_in_asserted = 1'b0;
  end

  // One pulse; the character is only valid beside rx_push, so it is inverted after.
  task automatic pulse(input logic [5:0] e, input logic [15:0] c);
    @(posedge clock);
    evt <= sfq_pkg::sfq_evt_s'(e);
    rx_char <= c; // Always full 16-bit characters, never 2 or 10 bits.
    @(posedge clock);
    evt <= '0;
    rx_char <= ~c;
    repeat (2) @(posedge clock);
  endtask

  // Select levels change after an edge and settle for edge detection.
  task automatic level(input logic sel, input logic mm);
    @(posedge clock);
    target_select_line <= sel;
    sel_in_asserted <= mm;
    repeat (3) @(posedge clock);
  endtask
endmodule

// >>> verification/test_spi_fifo_dma_irq_status.sv
module test_spi_fifo_dma_irq_status;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic [31:0] reg_rdata;
  logic [31:0] d;
  sfq_pkg::sfq_evt_s evt;
  logic [15:0] rx_char;
  logic [15:0] tx_char;
  logic tsl, sia, role, stall, rxq, txq, irq, wake;
  logic [7:0] trough;
  int err_total = 0;
  int checks_done = 0;

  // Free running 50 MHz clock.
  always #10 clock = ~clock;

  sfq_far_end i_far (.clock(clock), .evt(evt), .rx_char(rx_char),
    .target_select_line(tsl), .sel_in_asserted(sia));
  sfq_core i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .evt(evt), .rx_char(rx_char), .tx_char(tx_char), .target_select_line(tsl),
    .sel_in_asserted(sia), .controller_role_select(role), .sck_trough_count(trough),
    .sck_stall(stall), .rx_dma_req(rxq), .tx_dma_req(txq), .irq(irq), .wake(wake));

  ////////////////////////////////////////
  // Bus cycles: strobes last one cycle; the wait lets combinational outputs settle.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // Reset values, with an unmapped address that must read as zero.
  task automatic t_reset();
    logic [7:0] z[6] = '{8'h14, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h3c};
    foreach (z[i]) begin
      rd(z[i]);
      chk_reg(d, 32'h0);
    end
    rd(8'h1c);
    chk_reg(d, 32'h10);
    // An empty transmit queue is below the reset threshold, so its level flag is up too.
    rd(8'h20);
    chk_reg(d, 32'h3);
    $display("reset test done");
  endtask

  task automatic t_trough();
    wr(8'h14, 32'ha5);
    rd(8'h14);
    chk_reg(d, 32'ha5);
    chk_reg({24'h0, trough}, 32'ha5);
    $display("trough test done");
  endtask

  // Transmit queue: threshold, fill to full, overrun, clear and DMA masking.
  task automatic t_tx();
    wr(8'h1c, 32'h44);
    for (int i = 0; i < 3; i++) begin
      wr(8'h38, 32'h1230 + i);
    end
    wr(8'h20, 32'h2);
    rd(8'h1c);
    chk_reg(32'(d[13:8]), 32'h3);
    chk_reg({16'h0, tx_char}, 32'h1230);
    rd(8'h20);
    chk_bit(d[0], 1'b1);
    chk_bit(d[1], 1'b0);
    wr(8'h1c, 32'h8044);
    chk_bit(txq, 1'b1);
    for (int i = 0; i < 29; i++) begin
      wr(8'h38, 32'(i));
    end
    rd(8'h1c);
    chk_reg(32'(d[13:8]), 32'h20);
    chk_bit(txq, 1'b0);
    wr(8'h38, 32'h5555);
    rd(8'h20);
    chk_bit(d[12], 1'b1);
    wr(8'h24, 32'h1000);
    chk_bit(irq, 1'b1);
    wr(8'h20, 32'h1000);
    chk_bit(irq, 1'b0);
    wr(8'h1c, 32'h80c4);
    rd(8'h1c);
    chk_reg(32'(d[13:8]), 32'h0);
    chk_bit(txq, 1'b1);
    wr(8'h1c, 32'h44);
    chk_bit(txq, 1'b0);
    wr(8'h24, 32'h2);
    chk_bit(irq, 1'b1);
    wr(8'h1c, 32'h8044);
    chk_bit(irq, 1'b0);
    wr(8'h1c, 32'h44);
    wr(8'h24, 32'h0);
    wr(8'h2c, 32'h2);
    rd(8'h28);
    chk_reg(d, 32'h2);
    chk_bit(wake, 1'b1);
    wr(8'h2c, 32'h0);
    wr(8'h28, 32'h2);
    rd(8'h28);
    chk_reg(d, 32'h0);
    chk_bit(wake, 1'b0);
    $display("tx test done");
  endtask

  // Receive queue: bad threshold, level, underrun, full in both roles, clear.
  task automatic t_rx();
    wr(8'h1c, 32'h00420000);
    wr(8'h1c, 32'h005f0000);
    rd(8'h1c);
    chk_reg(32'(d[20:16]), 32'h2);
    for (int i = 0; i < 3; i++) begin
      rd(8'h20);
      chk_bit(d[2], 1'b0);
      i_far.pulse(6'h20, 16'(16'h0a10 + i));
    end
    rd(8'h20);
    chk_bit(d[2], 1'b1);
    // One transmit word keeps the empty-queue stall out of the full-queue stall check.
    wr(8'h1c, 32'h80420050);
    chk_bit(rxq, 1'b1);
    wr(8'h38, 32'h4321);
    for (int i = 0; i < 3; i++) begin
      rd(8'h38);
      chk_reg(32'(d[15:0]), 32'h0a10 + i);
    end
    chk_bit(rxq, 1'b0);
    rd(8'h38);
    rd(8'h20);
    chk_bit(d[15], 1'b1);
    wr(8'h20, 32'h8000);
    rd(8'h20);
    chk_bit(d[15], 1'b0);
    wr(8'h34, 32'h2);
    chk_bit(stall, 1'b0);
    for (int i = 0; i < 33; i++) begin
      i_far.pulse(6'h20, 16'(i));
    end
    chk_bit(stall, 1'b1);
    rd(8'h20);
    chk_bit(d[3], 1'b1);
    chk_bit(d[14], 1'b0);
    wr(8'h34, 32'h0);
    i_far.pulse(6'h20, 16'h7777);
    rd(8'h20);
    chk_bit(d[14], 1'b1);
    wr(8'h1c, 32'h00420000);
    chk_bit(rxq, 1'b0);
    wr(8'h1c, 32'h00c20080);
    rd(8'h1c);
    chk_reg(32'(d[29:24]), 32'h0);
    chk_reg(32'(d[13:8]), 32'h0);
    rd(8'h20);
    chk_reg(32'(d[3:2]), 32'h0);
    $display("rx test done");
  endtask

  // Transmit underrun in slave mode, clock stall instead in master mode.
  task automatic t_und();
    i_far.pulse(6'h10, 16'h0);
    rd(8'h20);
    chk_bit(d[13], 1'b1);
    wr(8'h20, 32'h2000);
    wr(8'h34, 32'h2);
    chk_bit(role, 1'b1);
    chk_bit(stall, 1'b1);
    i_far.pulse(6'h10, 16'h0);
    rd(8'h20);
    chk_bit(d[13], 1'b0);
    // The transmit queue is still disabled, so this word must be dropped.
    wr(8'h38, 32'h1);
    chk_bit(stall, 1'b1);
    wr(8'h1c, 32'h50);
    wr(8'h38, 32'h1);
    chk_bit(stall, 1'b0);
    wr(8'h1c, 32'hc4);
    $display("underrun test done");
  endtask

  // Select edges, abort, busy in both roles, fault and done.
  task automatic t_sel();
    wr(8'h34, 32'h0);
    i_far.level(1'b1, 1'b0);
    rd(8'h20);
    chk_bit(d[4], 1'b1);
    rd(8'h30);
    chk_reg(d, 32'h1);
    i_far.pulse(6'h08, 16'h0);
    i_far.level(1'b0, 1'b0);
    rd(8'h20);
    chk_reg(32'(d[9:5]), 32'h11);
    rd(8'h30);
    chk_reg(d, 32'h0);
    wr(8'h34, 32'h6);
    i_far.level(1'b0, 1'b1);
    rd(8'h20);
    chk_bit(d[8], 1'b1);
    i_far.level(1'b0, 1'b0);
    wr(8'h20, 32'h100);
    rd(8'h20);
    chk_bit(d[8], 1'b0);
    i_far.pulse(6'h04, 16'h0);
    rd(8'h20);
    chk_bit(d[8], 1'b1);
    i_far.pulse(6'h02, 16'h0);
    rd(8'h30);
    chk_reg(d, 32'h1);
    i_far.pulse(6'h01, 16'h0);
    rd(8'h30);
    chk_reg(d, 32'h0);
    rd(8'h20);
    chk_bit(d[11], 1'b1);
    $display("select test done");
  endtask

  // Main sequence: eight cycles of reset, then every scenario in turn.
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_trough();
    t_tx();
    t_rx();
    t_und();
    t_sel();
    stop_test();
  end

  // A hang is cut short and counted as a mismatch.
  initial begin
    #500000;
    err_total++;
    stop_test();
  end
endmodule
